// ### sbd_pkg.sv
package sbd_pkg;

  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [7:0] CTRL_OFF     = 8'h00;
  localparam logic [7:0] INSTR_OFF    = 8'h04;
  localparam logic [7:0] BASE_OFF     = 8'h08;
  localparam logic [7:0] SRC_OFF      = 8'h0c;
  localparam logic [7:0] SRC2_OFF     = 8'h10;
  localparam logic [7:0] OFFV_OFF     = 8'h14;
  localparam logic [7:0] STATUS_OFF   = 8'h18;
  localparam logic [7:0] NEWBASE_OFF  = 8'h1c;
  localparam logic [7:0] INT_ST_OFF   = 8'h20;
  localparam logic [7:0] INT_MSK_OFF  = 8'h24;

  // ********************************************************
  // Field positions and reset values
  // ********************************************************
  localparam int CTRL_COND_BIT  = 0;
  localparam int CTRL_CARRY_BIT = 1;
  localparam logic [2:0] CTRL_RST    = 3'h1;
  localparam logic [3:0] INT_MSK_RST = 4'h0;
  localparam int INT_DONE  = 0;
  localparam int INT_UNDEF = 1;
  localparam int INT_PROT  = 2;
  localparam int INT_BUS   = 3;

  // ********************************************************
  // Encoding patterns
  // ********************************************************
  localparam logic [4:0]  OP16_IMM   = 5'h0e;
  localparam logic [6:0]  OP16_REG   = 7'h2a;
  localparam logic [11:0] OP32_WIDE  = 12'hf88;
  localparam logic [11:0] OP32_NARW  = 12'hf80;
  localparam logic [6:0]  OP32_PAIR  = 7'h74;
  localparam logic [3:0]  REG_PC     = 4'hf;
  localparam logic [3:0]  REG_SP     = 4'hd;
  localparam logic [2:0]  PUW_UNPRIV = 3'h6;
  localparam logic [31:0] PAIR_STEP  = 32'h0000_0004;

  // ********************************************************
  // Access size codes and states
  // ********************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef enum logic [1:0] {
    SBD_IDLE   = 2'b00,
    SBD_DECODE = 2'b01,
    SBD_WR1    = 2'b10,
    SBD_WR2    = 2'b11
  } sbd_state_t;

endpackage : sbd_pkg

// ### sbd_store_unit.sv
`timescale 1ns/1ns
module sbd_store_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  output logic      [1:0]  mem_size,
  output logic             mem_unpriv,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic        mem_prot_err,
  output logic             irq
);

  // ********************************************************
  // State record
  // ********************************************************
  typedef struct packed {
    sbd_pkg::sbd_state_t state;
    logic [2:0]  ctrl;
    logic [31:0] instr;
    logic [31:0] base;
    logic [31:0] src;
    logic [31:0] src2;
    logic [31:0] offv;
    logic        undef;
    logic        unpred;
    logic        other;
    logic        skipped;
    logic        based;
    logic        shc;
    logic [3:0]  rn;
    logic [31:0] new_base;
    logic        pair;
    logic        wb;
    logic [3:0]  int_st;
    logic [3:0]  int_msk;
    logic        mem_req;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [1:0]  mem_size;
    logic        mem_unpriv;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } sbd_regs_t;

  sbd_regs_t   r_reg;
  sbd_regs_t   r_next;

  // Decode results
  logic        d_store;
  logic        d_undef;
  logic        d_unpred;
  logic        d_other;
  logic        d_pair;
  logic        d_unpriv;
  logic        d_index;
  logic        d_add;
  logic        d_wb;
  logic        d_use_reg;
  logic [1:0]  d_shn;
  logic [3:0]  d_rn;
  logic [31:0] d_imm;
  logic [31:0] d_off_addr;
  logic [31:0] d_addr;
  logic        d_shc;

  // ********************************************************
  // Helpers
  // ********************************************************
  // Stack pointer or program counter
  function automatic logic sbd_sp_pc(input logic [3:0] r);
    sbd_sp_pc = (r == sbd_pkg::REG_SP) || (r == sbd_pkg::REG_PC);
  endfunction : sbd_sp_pc

  // Logical left shift with carry in; returns carry out and value
  function automatic logic [32:0] sbd_lsl(input logic [31:0] v, input logic [1:0] n,
                                          input logic cin);
    logic [63:0] w;
    w = {32'h0000_0000, v} << n;
    sbd_lsl = (n == 2'h0) ? {cin, v} : w[32:0];
  endfunction : sbd_lsl

  // ********************************************************
  // Instruction decode
  // ********************************************************
  always_comb begin
    logic [15:0] h1;
    logic [15:0] h2;
    logic [3:0]  rt;
    logic [3:0]  rt2;
    logic [3:0]  rm;
    logic [32:0] sh;
    logic [31:0] offset;
    h1 = r_reg.instr[31:16];
    h2 = r_reg.instr[15:0];
    rt = h2[15:12];
    rt2 = h2[11:8];
    rm = h2[3:0];
    sh = 33'h0;
    offset = 32'h0000_0000;
    d_store = 1'b0;
    d_undef = 1'b0;
    d_unpred = 1'b0;
    d_other = 1'b0;
    d_pair = 1'b0;
    d_unpriv = 1'b0;
    d_index = 1'b1;
    d_add = 1'b1;
    d_wb = 1'b0;
    d_use_reg = 1'b0;
    d_shn = 2'h0;
    d_rn = h1[3:0];
    d_imm = 32'h0000_0000;
    if (h1[15:11] == sbd_pkg::OP16_IMM) begin
      d_store = 1'b1;
      d_rn = {1'b0, h1[5:3]};
      d_imm = {27'h0000000, h1[10:6]};
    end else if (h1[15:9] == sbd_pkg::OP16_REG) begin
      d_store = 1'b1;
      d_rn = {1'b0, h1[5:3]};
      d_use_reg = 1'b1;
    end else if (h1[15:4] == sbd_pkg::OP32_WIDE) begin
      d_store = 1'b1;
      d_imm = {20'h00000, h2[11:0]};
      d_undef = (d_rn == sbd_pkg::REG_PC);
      d_unpred = sbd_sp_pc(rt);
    end else if (h1[15:4] == sbd_pkg::OP32_NARW && h2[11]) begin
      d_store = 1'b1;
      d_imm = {24'h000000, h2[7:0]};
      if (h2[10:8] == sbd_pkg::PUW_UNPRIV) begin
        d_unpriv = 1'b1;
        d_undef = (d_rn == sbd_pkg::REG_PC);
        d_unpred = sbd_sp_pc(rt);
      end else begin
        d_index = h2[10];
        d_add = h2[9];
        d_wb = h2[8];
        d_undef = (d_rn == sbd_pkg::REG_PC) || (!h2[10] && !h2[8]);
        d_unpred = sbd_sp_pc(rt) || (h2[8] && d_rn == rt);
      end
    end else if (h1[15:4] == sbd_pkg::OP32_NARW && h2[11:6] == 6'h00) begin
      d_store = 1'b1;
      d_use_reg = 1'b1;
      d_shn = h2[5:4];
      d_undef = (d_rn == sbd_pkg::REG_PC);
      d_unpred = sbd_sp_pc(rt) || sbd_sp_pc(rm);
    end else if (h1[15:9] == sbd_pkg::OP32_PAIR && h1[6] && !h1[4]) begin
      if (!h1[8] && !h1[5]) begin
        d_other = 1'b1;
      end else begin
        d_store = 1'b1;
        d_pair = 1'b1;
        d_imm = {22'h000000, h2[7:0], 2'b00};
        d_index = h1[8];
        d_add = h1[7];
        d_wb = h1[5];
        d_unpred = (h1[5] && (d_rn == rt || d_rn == rt2)) || d_rn == sbd_pkg::REG_PC
                   || sbd_sp_pc(rt) || sbd_sp_pc(rt2);
      end
    end else begin
      d_other = 1'b1;
    end
    sh = sbd_lsl(r_reg.offv, d_shn, r_reg.ctrl[sbd_pkg::CTRL_CARRY_BIT]);
    d_shc = sh[32];
    offset = d_use_reg ? sh[31:0] : d_imm;
    d_off_addr = d_add ? r_reg.base + offset : r_reg.base - offset;
    d_addr = d_index ? d_off_addr : r_reg.base;
  end

  // ********************************************************
  // Next state: bus slave, sequencer, interrupts
  // ********************************************************
  always_comb begin
    logic       setup;
    logic       acc_wr;
    logic       busy;
    logic [3:0] iset;
    logic [3:0] iclr;
    logic       ok;
    r_next = r_reg;
    setup = psel && !penable;
    acc_wr = psel && penable && r_reg.pready && pwrite && !r_reg.pslverr;
    busy = (r_reg.state != sbd_pkg::SBD_IDLE);
    iset = 4'h0;
    iclr = 4'h0;
    ok = 1'b0;
    // Register reads and refusal decided in setup phase
    r_next.pready = setup;
    if (setup) begin
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
      case (paddr[7:0])
        sbd_pkg::CTRL_OFF:    r_next.prdata = {29'h0, r_reg.ctrl};
        sbd_pkg::INSTR_OFF:   r_next.prdata = r_reg.instr;
        sbd_pkg::BASE_OFF:    r_next.prdata = r_reg.base;
        sbd_pkg::SRC_OFF:     r_next.prdata = r_reg.src;
        sbd_pkg::SRC2_OFF:    r_next.prdata = r_reg.src2;
        sbd_pkg::OFFV_OFF:    r_next.prdata = r_reg.offv;
        sbd_pkg::STATUS_OFF:  r_next.prdata = {20'h0, r_reg.rn, 1'b0, r_reg.shc,
                                 r_reg.skipped, r_reg.based, r_reg.other, r_reg.unpred,
                                 r_reg.undef, busy};
        sbd_pkg::NEWBASE_OFF: r_next.prdata = r_reg.new_base;
        sbd_pkg::INT_ST_OFF:  r_next.prdata = {28'h0, r_reg.int_st};
        sbd_pkg::INT_MSK_OFF: r_next.prdata = {28'h0, r_reg.int_msk};
        default:              r_next.pslverr = 1'b1;
      endcase
      // Operand and command writes refused while a store runs
      if (pwrite && busy && paddr[7:0] <= sbd_pkg::OFFV_OFF) begin
        r_next.pslverr = 1'b1;
      end
      if (pwrite && (paddr[7:0] == sbd_pkg::STATUS_OFF || paddr[7:0] == sbd_pkg::NEWBASE_OFF))
      begin
        r_next.pslverr = 1'b1;
      end
    end
    if (acc_wr) begin
      case (paddr[7:0])
        sbd_pkg::CTRL_OFF:    r_next.ctrl = pwdata[2:0];
        sbd_pkg::INSTR_OFF: begin
          r_next.instr = pwdata;
          r_next.state = sbd_pkg::SBD_DECODE;
        end
        sbd_pkg::BASE_OFF:    r_next.base = pwdata;
        sbd_pkg::SRC_OFF:     r_next.src = pwdata;
        sbd_pkg::SRC2_OFF:    r_next.src2 = pwdata;
        sbd_pkg::OFFV_OFF:    r_next.offv = pwdata;
        sbd_pkg::INT_ST_OFF:  iclr = pwdata[3:0];
        sbd_pkg::INT_MSK_OFF: r_next.int_msk = pwdata[3:0];
        default: ;
      endcase
    end
    // Store sequencer
    case (r_reg.state)
      sbd_pkg::SBD_IDLE: ;
      sbd_pkg::SBD_DECODE: begin
        r_next.undef = d_undef;
        r_next.unpred = d_unpred;
        r_next.other = d_other;
        r_next.skipped = 1'b0;
        r_next.based = 1'b0;
        r_next.shc = d_shc;
        r_next.rn = d_rn;
        r_next.pair = d_pair;
        r_next.wb = d_wb;
        r_next.new_base = d_off_addr;
        r_next.state = sbd_pkg::SBD_IDLE;
        if (!r_reg.ctrl[sbd_pkg::CTRL_COND_BIT]) begin
          r_next.skipped = 1'b1;
          iset[sbd_pkg::INT_DONE] = 1'b1;
        end else if (d_undef || !d_store) begin
          iset[sbd_pkg::INT_UNDEF] = 1'b1;
        end else begin
          r_next.mem_req = 1'b1;
          r_next.mem_addr = d_addr;
          r_next.mem_unpriv = d_unpriv;
          if (d_pair) begin
            r_next.mem_size = sbd_pkg::SIZE_WORD;
            r_next.mem_wdata = r_reg.src;
          end else begin
            r_next.mem_size = sbd_pkg::SIZE_BYTE;
            r_next.mem_wdata = {24'h000000, r_reg.src[7:0]};
          end
          r_next.state = sbd_pkg::SBD_WR1;
        end
      end
      sbd_pkg::SBD_WR1, sbd_pkg::SBD_WR2: begin
        if (mem_ack) begin
          r_next.mem_req = 1'b0;
          r_next.mem_unpriv = 1'b0;
          r_next.state = sbd_pkg::SBD_IDLE;
          if (mem_err) begin
            iset[sbd_pkg::INT_PROT] = mem_prot_err;
            iset[sbd_pkg::INT_BUS] = !mem_prot_err;
          end else if (r_reg.state == sbd_pkg::SBD_WR1 && r_reg.pair) begin
            r_next.mem_req = 1'b1;
            r_next.mem_addr = r_reg.mem_addr + sbd_pkg::PAIR_STEP;
            r_next.mem_wdata = r_reg.src2;
            r_next.state = sbd_pkg::SBD_WR2;
          end else begin
            ok = 1'b1;
          end
        end
      end
      default: r_next.state = sbd_pkg::SBD_IDLE;
    endcase
    // Writeback only after every write succeeded
    if (ok) begin
      iset[sbd_pkg::INT_DONE] = 1'b1;
      if (r_reg.wb) begin
        r_next.base = r_reg.new_base;
        r_next.based = 1'b1;
      end
    end
    // Sticky status, set wins over clear
    r_next.int_st = (r_reg.int_st & ~iclr) | iset;
    r_next.irq = |(r_next.int_st & r_next.int_msk);
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.state <= sbd_pkg::SBD_IDLE;
      r_reg.ctrl <= sbd_pkg::CTRL_RST;
      r_reg.int_msk <= sbd_pkg::INT_MSK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign mem_req = r_reg.mem_req;
  assign mem_addr = r_reg.mem_addr;
  assign mem_wdata = r_reg.mem_wdata;
  assign mem_size = r_reg.mem_size;
  assign mem_unpriv = r_reg.mem_unpriv;
  assign irq = r_reg.irq;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_undef_blocks;
    r_reg.state == sbd_pkg::SBD_DECODE && r_reg.ctrl[0] && d_undef
      |=> !mem_req && r_reg.int_st[sbd_pkg::INT_UNDEF] && r_reg.state == sbd_pkg::SBD_IDLE;
  endproperty
  a_undef_blocks: assert property (p_undef_blocks)
    else $error("undefined store issued a write");

  property p_cond_fail;
    r_reg.state == sbd_pkg::SBD_DECODE && !r_reg.ctrl[0] |=> !mem_req ##1 $stable(r_reg.base);
  endproperty
  a_cond_fail: assert property (p_cond_fail)
    else $error("store ran with failed condition");

  property p_other_pair;
    r_reg.state == sbd_pkg::SBD_DECODE && d_other |=> !mem_req [*2];
  endproperty
  a_other_pair: assert property (p_other_pair)
    else $error("non-store pair encoding issued a write");

  property p_byte_data;
    mem_req && !r_reg.pair |-> mem_size == sbd_pkg::SIZE_BYTE && mem_wdata[31:8] == 24'h0;
  endproperty
  a_byte_data: assert property (p_byte_data)
    else $error("byte store wrote more than its low byte");

  property p_second_word;
    r_reg.state == sbd_pkg::SBD_WR1 && mem_ack && !mem_err && r_reg.pair
      |=> mem_req && mem_addr == $past(mem_addr) + 32'h4 && mem_wdata == r_reg.src2;
  endproperty
  a_second_word: assert property (p_second_word)
    else $error("second pair word misplaced");

  property p_unpriv;
    r_reg.state == sbd_pkg::SBD_DECODE && r_reg.ctrl[0] && d_unpriv && !d_undef
      |=> mem_req && mem_unpriv && mem_addr == $past(r_reg.base) + $past(d_imm);
  endproperty
  a_unpriv: assert property (p_unpriv)
    else $error("unprivileged store wrong");

  property p_fault_no_wb;
    r_reg.state != sbd_pkg::SBD_IDLE && r_reg.state != sbd_pkg::SBD_DECODE && mem_ack && mem_err
      |=> r_reg.base == $past(r_reg.base) && !mem_req && r_reg.int_st[3:2] != 2'b00;
  endproperty
  a_fault_no_wb: assert property (p_fault_no_wb)
    else $error("faulted store updated base or raised no fault");

  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("write request dropped before acknowledge");

  property p_short_imm;
    r_reg.state == sbd_pkg::SBD_DECODE && r_reg.instr[31:27] == sbd_pkg::OP16_IMM
      |-> d_addr == r_reg.base + {27'h0, r_reg.instr[26:22]} && !d_wb;
  endproperty
  a_short_imm: assert property (p_short_imm)
    else $error("short immediate address wrong");

endmodule : sbd_store_unit

// ### sbd_mem_model.sv
`timescale 1ns/1ns
module sbd_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  input  wire logic        mem_unpriv,
  input  wire logic [7:0]  lat,
  input  wire logic [1:0]  fail_mode,
  output logic             mem_ack,
  output logic             mem_err,
  output logic             mem_prot_err
);
  // ********************************************************
  // Write log seen by the bench
  // ********************************************************
  logic [7:0]  wait_cnt;
  logic [31:0] wr_cnt;
  logic [31:0] log_addr [4];
  logic [31:0] log_data [4];
  logic [1:0]  log_size [4];
  logic        log_up   [4];

  // Acks after lat idle cycles, error lines wander outside an ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack      <= 1'b0;
      mem_err      <= 1'b0;
      mem_prot_err <= 1'b1;
      wait_cnt     <= 8'h00;
      wr_cnt       <= 32'h0;
    end else begin
      mem_err      <= ~mem_err;
      mem_prot_err <= ~mem_prot_err;
      if (mem_ack && mem_req) begin
        log_addr[wr_cnt[1:0]] <= mem_addr;
        log_data[wr_cnt[1:0]] <= mem_wdata;
        log_size[wr_cnt[1:0]] <= mem_size;
        log_up[wr_cnt[1:0]]   <= mem_unpriv;
        wr_cnt                <= wr_cnt + 32'h1;
        mem_ack               <= 1'b0;
        wait_cnt              <= 8'h00;
      end else if (!mem_req) begin
        mem_ack  <= 1'b0;
        wait_cnt <= 8'h00;
      end else if (wait_cnt == lat) begin
        mem_ack      <= 1'b1;
        mem_err      <= (fail_mode != 2'h0);
        mem_prot_err <= (fail_mode == 2'h1);
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule : sbd_mem_model

// ### store_byte_and_pair_decode_tb.sv
`timescale 1ns/1ns
module store_byte_and_pair_decode_tb;
  // ********************************************************
  // Signals and operand values
  // ********************************************************
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [31:0] paddr     = 32'h0;
  logic [31:0] pwdata    = 32'h0;
  logic [7:0]  lat       = 8'h00;
  logic [1:0]  fail_mode = 2'h0;
  logic        cond_v    = 1'b1;
  logic        carry_v   = 1'b0;
  logic [31:0] prdata, mem_addr, mem_wdata, rv;
  logic        pready, pslverr, mem_req, mem_unpriv, mem_ack, mem_err, mem_prot_err, irq, ev;
  logic [1:0]  mem_size;
  int          bad_count = 0;
  int          checked   = 0;
  localparam logic [31:0] BASE_V = 32'h0000_1000;
  localparam logic [31:0] SRC_V  = 32'h1234_56a5;
  localparam logic [31:0] SRC2_V = 32'hcafe_0001;
  localparam logic [31:0] OFF_V  = 32'h0000_0013;
  localparam logic [1:0]  SB     = sbd_pkg::SIZE_BYTE;
  localparam logic [1:0]  SW     = sbd_pkg::SIZE_WORD;
  localparam logic [2:0]  UP     = sbd_pkg::PUW_UNPRIV;

  // Clock
  always #50 pclk = ~pclk;

  sbd_store_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_size(mem_size), .mem_unpriv(mem_unpriv), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_prot_err(mem_prot_err), .irq(irq));

  sbd_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_unpriv(mem_unpriv), .lat(lat),
    .fail_mode(fail_mode), .mem_ack(mem_ack), .mem_err(mem_err), .mem_prot_err(mem_prot_err));

  // ********************************************************
  // Encoders
  // ********************************************************
  function automatic logic [31:0] t3(input logic [3:0] rn, input logic [3:0] rt,
                                     input logic [2:0] puw, input logic [7:0] i8);
    return {sbd_pkg::OP32_NARW, rn, rt, 1'b1, puw, i8};
  endfunction : t3
  function automatic logic [31:0] wd(input logic [3:0] rn, input logic [3:0] rt,
                                     input logic [11:0] i12);
    return {sbd_pkg::OP32_WIDE, rn, rt, i12};
  endfunction : wd
  function automatic logic [31:0] rg2(input logic [3:0] rn, input logic [3:0] rm,
                                      input logic [1:0] s);
    return {sbd_pkg::OP32_NARW, rn, 4'd2, 6'h00, s, rm};
  endfunction : rg2
  function automatic logic [31:0] pr(input logic [3:0] rt2, input logic [2:0] puw,
                                     input logic [7:0] i8);
    return {sbd_pkg::OP32_PAIR, puw[2], puw[1], 1'b1, puw[0], 1'b0, 4'd1, 4'd2, rt2, i8};
  endfunction : pr
  // Short immediate form, base register 1, source register 2
  function automatic logic [31:0] s16(input logic [4:0] i5);
    return {sbd_pkg::OP16_IMM, i5, 3'd1, 3'd2, 16'h0};
  endfunction : s16

  // ********************************************************
  // Bus and check tasks
  // ********************************************************
  task finish_test;
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {24'h0, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  task wait_idle;
    logic [31:0] r;
    int          n;
    n = 0;
    do begin
      rd(sbd_pkg::STATUS_OFF, r);
      n++;
    end while (r[0] !== 1'b0 && n < 200);
    chk({31'h0, r[0]}, 32'h0);
  endtask : wait_idle

  // One store: load operands, issue, compare memory log, base, status, events
  task do_case(input logic [31:0] ins, input logic [1:0] nw, input logic [31:0] a0,
               input logic [1:0] sz, input logic up, input logic [31:0] bexp,
               input logic [31:0] st, input logic [3:0] ie);
    logic [31:0] c0, d0, r;
    logic [1:0]  i0;
    wr(sbd_pkg::CTRL_OFF, {30'h0, carry_v, cond_v});
    wr(sbd_pkg::BASE_OFF, BASE_V);
    wr(sbd_pkg::SRC_OFF, SRC_V);
    wr(sbd_pkg::SRC2_OFF, SRC2_V);
    wr(sbd_pkg::OFFV_OFF, OFF_V);
    c0 = mem.wr_cnt;
    i0 = c0[1:0];
    d0 = (sz === SB) ? {24'h0, SRC_V[7:0]} : SRC_V;
    wr(sbd_pkg::INSTR_OFF, ins);
    wait_idle;
    chk(mem.wr_cnt - c0, {30'h0, nw});
    if (nw != 2'd0) begin
      chk(mem.log_addr[i0], a0);
      chk(mem.log_data[i0], d0);
      chk({30'h0, mem.log_size[i0]}, {30'h0, sz});
      chk({31'h0, mem.log_up[i0]}, {31'h0, up});
    end
    if (nw == 2'd2) begin
      chk(mem.log_addr[i0 + 2'd1], a0 + sbd_pkg::PAIR_STEP);
      chk(mem.log_data[i0 + 2'd1], SRC2_V);
    end
    rd(sbd_pkg::BASE_OFF, r);
    chk(r, bexp);
    rd(sbd_pkg::STATUS_OFF, r);
    chk(r & 32'h7e, st);
    rd(sbd_pkg::INT_ST_OFF, r);
    chk(r & (ie[0] ? 32'hf : 32'he), {28'h0, ie});
    wr(sbd_pkg::INT_ST_OFF, 32'hf);
  endtask : do_case

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(sbd_pkg::CTRL_OFF, rv);
    chk(rv, 32'h1);
    rd(sbd_pkg::INT_MSK_OFF, rv);
    chk(rv, 32'h0);
    apb(1'b0, 8'h40, 32'h0, rv, ev);
    chk({31'h0, ev}, 32'h1);
    apb(1'b1, sbd_pkg::STATUS_OFF, 32'h1, rv, ev);
    chk({31'h0, ev}, 32'h1);
    do_case(s16(5'd31), 1, BASE_V + 32'd31, SB, 0, BASE_V, 0, 1);
    do_case(s16(5'd0), 2'd1, BASE_V, SB, 0, BASE_V, 0, 1);
    do_case(wd(4'd3, 4'd4, 12'hfff), 1, BASE_V + 32'hfff, SB, 0, BASE_V, 0, 1);
    do_case(t3(4'd1, 4'd2, 3'b101, 8'hff), 1, 32'h0f01, SB, 0, 32'h0f01, 32'h10, 1);
    do_case(t3(4'd1, 4'd2, 3'b011, 8'h10), 1, BASE_V, SB, 0, 32'h1010, 32'h10, 1);
    do_case(t3(4'd1, 4'd2, 3'b100, 8'h04), 1, 32'h0ffc, SB, 0, BASE_V, 0, 1);
    do_case(t3(4'd1, 4'd2, UP, 8'h80), 1, 32'h1080, SB, 1, BASE_V, 0, 1);
    do_case({sbd_pkg::OP16_REG, 3'd3, 3'd1, 3'd2, 16'h0}, 1, BASE_V + OFF_V, SB, 0, BASE_V,
            0, 1);
    for (int s = 0; s < 4; s++) begin
      do_case(rg2(4'd1, 4'd3, s[1:0]), 1, BASE_V + (OFF_V << s), SB, 0, BASE_V, 0, 1);
    end
    // Carry flag in reaches the shifter carry-out status bit
    carry_v = 1'b1;
    do_case(rg2(4'd1, 4'd3, 2'd0), 1, BASE_V + OFF_V, SB, 0, BASE_V, 32'h40, 1);
    carry_v = 1'b0;
    do_case(pr(4'd3, 3'b111, 8'hff), 2, 32'h13fc, SW, 0, 32'h13fc, 32'h10, 1);
    do_case(pr(4'd3, 3'b001, 8'h01), 2, BASE_V, SW, 0, 32'h0ffc, 32'h10, 1);
    do_case(pr(4'd3, 3'b100, 8'h02), 2, 32'h0ff8, SW, 0, BASE_V, 0, 1);
    do_case(pr(4'd3, 3'b010, 8'h02), 0, 0, SW, 0, BASE_V, 32'h08, 2);
    do_case(wd(4'hf, 4'd4, 12'h001), 0, 0, SB, 0, BASE_V, 32'h02, 2);
    do_case(t3(4'd1, 4'd2, 3'b010, 8'h01), 0, 0, SB, 0, BASE_V, 32'h02, 2);
    do_case(rg2(4'hf, 4'd3, 2'd0), 0, 0, SB, 0, BASE_V, 32'h02, 2);
    do_case(t3(4'hf, 4'd2, sbd_pkg::PUW_UNPRIV, 8'h01), 0, 0, SB, 0, BASE_V, 32'h02, 2);
    do_case(wd(4'd3, 4'hf, 12'h002), 1, 32'h1002, SB, 0, BASE_V, 32'h04, 1);
    do_case(t3(4'd1, 4'd1, 3'b111, 8'h08), 1, 32'h1008, SB, 0, 32'h1008, 32'h14, 1);
    do_case(rg2(4'd1, 4'hd, 2'd0), 1, BASE_V + OFF_V, SB, 0, BASE_V, 32'h04, 1);
    do_case(t3(4'd1, 4'hd, UP, 8'h01), 1, 32'h1001, SB, 1, BASE_V, 32'h04, 1);
    do_case(pr(4'hd, 3'b110, 8'h01), 2, 32'h1004, SW, 0, BASE_V, 32'h04, 1);
    cond_v = 1'b0;
    do_case(t3(4'd1, 4'd2, 3'b111, 8'h08), 0, 0, SB, 0, BASE_V, 32'h20, 1);
    cond_v = 1'b1;
    fail_mode <= 2'h1;
    do_case(s16(5'd0), 1, BASE_V, SB, 0, BASE_V, 0, 4);
    fail_mode <= 2'h2;
    do_case(pr(4'd3, 3'b111, 8'h01), 1, 32'h1004, SW, 0, BASE_V, 0, 8);
    fail_mode <= 2'h0;
    // Slow memory: operand writes refused while busy
    lat <= 8'd20;
    wr(sbd_pkg::INSTR_OFF, s16(5'd1));
    apb(1'b1, sbd_pkg::BASE_OFF, 32'h5555, rv, ev);
    chk({31'h0, ev}, 32'h1);
    wait_idle;
    rd(sbd_pkg::BASE_OFF, rv);
    chk(rv, BASE_V);
    lat <= 8'd0;
    // Interrupt output follows status and mask
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(sbd_pkg::INT_MSK_OFF, 32'h1);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(sbd_pkg::INT_ST_OFF, 32'h1);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(sbd_pkg::INT_MSK_OFF, rv);
    chk(rv, 32'h1);
    finish_test;
  end

  // Watchdog
  initial begin
    #5_000_000;
    bad_count++;
    finish_test;
  end
endmodule : store_byte_and_pair_decode_tb
